//--- rtl/spi_eeprom_cfg.svh
// constants for the serial eeprom command and protection block
`ifndef SPI_EEPROM_CFG_SVH
`define SPI_EEPROM_CFG_SVH
`define OP_SET_LATCH 8'h06
`define OP_CLR_LATCH 8'h04
`define OP_STAT_RD 8'h05
`define OP_STAT_WR 8'h01
`define OP_ARR_RD 8'h03
`define OP_ARR_WR 8'h02
`define SR_PPE_BIT 7
`define SR_BPH_BIT 3
`define SR_BPL_BIT 2
`define SR_LATCH_BIT 1
`define SR_WIP_BIT 0
`define SR_BUSY_VALUE 8'hFF
`define NV_RESET 3'h0
`define ARRAY_ADDR_W 10
`define PAGE_BYTES 32
`define PAGE_IDX_W 5
`define BP_QUARTER_BASE 10'h300
`define BP_HALF_BASE 10'h200
`define BYTES_MAX 6'h3F
`define CORE_CLK_MHZ 25
`define WRITE_TIME_US 5000
`define WRITE_CYCLES (`WRITE_TIME_US * `CORE_CLK_MHZ)
`endif

//--- rtl/spi_eeprom_pkg.sv
// types for the serial eeprom command and protection block
`default_nettype none
package spi_eeprom_pkg;
  typedef enum logic [2:0] {ph_opcode, ph_addr_hi, ph_addr_lo, ph_data, ph_ignore} phase_t;
  typedef logic [7:0] byte_t;
endpackage
`default_nettype wire

//--- rtl/spi_eeprom_command_protect.sv
// serial eeprom slave: command decode, write latch, status and block protection
`include "spi_eeprom_cfg.svh"
`default_nettype none
module spi_eeprom_command_protect #(
  parameter int WRITE_CYCLES = `WRITE_CYCLES
) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic sck_in,
  input wire logic cs_n_in,
  input wire logic si_in,
  input wire logic hold_n_in,
  input wire logic wp_n_in,
  output logic so_out,
  output logic so_oe_out,
  output spi_eeprom_pkg::byte_t status_out
);
  import spi_eeprom_pkg::*;

  localparam int CYC_W = $clog2(WRITE_CYCLES + 1);
  localparam int AW = `ARRAY_ADDR_W;

  function automatic logic is_protected(input logic [1:0] bp, input logic [AW-1:0] a);
    logic r;
    r = 1'b0;
    case (bp)
      2'b00: r = 1'b0;
      2'b01: r = (a >= `BP_QUARTER_BASE);
      2'b10: r = (a >= `BP_HALF_BASE);
      default: r = 1'b1;
    endcase
    return r;
  endfunction

  // ==========================================================
  // shared storage
  byte_t mem_ff [2**AW];
  byte_t page_buf_ff [`PAGE_BYTES];
  logic [`PAGE_BYTES-1:0] page_mask_ff;
  logic link_clr_ff;
  byte_t sr_value;

  // ==========================================================
  // link side: serial clock domain
  logic frame_start_ff;
  logic frame_id_ff;
  logic [2:0] bitpos_ff;
  byte_t shift_ff;
  byte_t op_ff;
  logic [15:0] addr_ff;
  logic [`PAGE_IDX_W-1:0] wr_idx_ff;
  logic [5:0] bytes_ff;
  logic exact_ff;
  byte_t stat_data_ff;
  byte_t tx_ff;
  phase_t phase_ff;
  logic [8:0] stat_meta_ff;
  logic [8:0] stat_q_ff;
  logic ready_ff;
  logic so_ff;

  logic [2:0] cur_bits;
  byte_t nxt_shift;
  logic byte_full;
  phase_t phase_v;
  logic [5:0] bytes_v;
  logic [AW-1:0] rd_next;
  logic link_busy;
  logic link_ready;

  assign cur_bits = frame_start_ff ? 3'h0 : bitpos_ff;
  assign nxt_shift = {(frame_start_ff ? 7'h00 : shift_ff[6:0]), si_in};
  assign byte_full = (cur_bits == 3'h7);
  assign phase_v = frame_start_ff ? ph_opcode : phase_ff;
  assign bytes_v = frame_start_ff ? 6'h00 : bytes_ff;
  assign rd_next = addr_ff[AW-1:0] + {{(AW-1){1'b0}}, 1'b1};
  assign link_busy = stat_q_ff[`SR_WIP_BIT];
  assign link_ready = stat_q_ff[8];

  // frame marker: set while deselected, cleared by first taken edge
  always_ff @(posedge sck_in or posedge cs_n_in or posedge link_clr_ff)
  begin
    if (cs_n_in)
      frame_start_ff <= 1'b1;
    else if (link_clr_ff)
      frame_start_ff <= 1'b1;
    else if (hold_n_in)
      frame_start_ff <= 1'b0;
  end

  // status and readiness into the link domain
  always_ff @(posedge sck_in or posedge link_clr_ff)
  begin
    if (link_clr_ff)
    begin
      stat_meta_ff <= 9'h000;
      stat_q_ff <= 9'h000;
    end
    else
    begin
      stat_meta_ff <= {ready_ff, sr_value};
      stat_q_ff <= stat_meta_ff;
    end
  end

  // receive sequencer; state holds while the clock stops
  always_ff @(posedge sck_in or posedge link_clr_ff)
  begin
    if (link_clr_ff)
    begin
      frame_id_ff <= 1'b0;
      bitpos_ff <= 3'h0;
      shift_ff <= 8'h00;
      op_ff <= 8'h00;
      addr_ff <= 16'h0000;
      wr_idx_ff <= '0;
      bytes_ff <= 6'h00;
      exact_ff <= 1'b0;
      stat_data_ff <= 8'h00;
      tx_ff <= 8'h00;
      phase_ff <= ph_ignore;
      page_mask_ff <= '0;
    end
    else if (hold_n_in)
    begin
      if (frame_start_ff)
      begin
        frame_id_ff <= ~frame_id_ff;
        page_mask_ff <= '0;
      end
      bitpos_ff <= cur_bits + 3'h1;
      shift_ff <= nxt_shift;
      exact_ff <= byte_full;
      if (byte_full && bytes_v != `BYTES_MAX)
        bytes_ff <= bytes_v + 6'h01;
      else
        bytes_ff <= bytes_v;
      phase_ff <= phase_v;
      if (byte_full)
      begin
        case (phase_v)
          ph_opcode:
          begin
            op_ff <= nxt_shift;
            if (!link_ready)
              phase_ff <= ph_ignore;
            else if (link_busy && nxt_shift != `OP_STAT_RD)
              phase_ff <= ph_ignore;
            else
            begin
              case (nxt_shift)
                `OP_ARR_RD: phase_ff <= ph_addr_hi;
                `OP_ARR_WR: phase_ff <= ph_addr_hi;
                `OP_STAT_WR: phase_ff <= ph_data;
                `OP_STAT_RD:
                begin
                  phase_ff <= ph_data;
                  tx_ff <= stat_q_ff[7:0];
                end
                default: phase_ff <= ph_ignore;
              endcase
            end
          end
          ph_addr_hi:
          begin
            addr_ff[15:8] <= nxt_shift;
            phase_ff <= ph_addr_lo;
          end
          ph_addr_lo:
          begin
            addr_ff[7:0] <= nxt_shift;
            wr_idx_ff <= nxt_shift[`PAGE_IDX_W-1:0];
            tx_ff <= mem_ff[{addr_ff[9:8], nxt_shift}];
            phase_ff <= ph_data;
          end
          ph_data:
          begin
            case (op_ff)
              `OP_ARR_RD:
              begin
                addr_ff[AW-1:0] <= rd_next;
                tx_ff <= mem_ff[rd_next];
              end
              `OP_STAT_RD: tx_ff <= stat_q_ff[7:0];
              `OP_ARR_WR:
              begin
                page_buf_ff[wr_idx_ff] <= nxt_shift;
                page_mask_ff[wr_idx_ff] <= 1'b1;
                wr_idx_ff <= wr_idx_ff + 1'b1;
              end
              `OP_STAT_WR:
              begin
                if (bytes_v == 6'h01)
                  stat_data_ff <= nxt_shift;
              end
              default: phase_ff <= ph_ignore;
            endcase
          end
          default: phase_ff <= ph_ignore;
        endcase
      end
    end
  end

  // transmit: next bit after each falling edge, msb first
  always_ff @(negedge sck_in or posedge cs_n_in)
  begin
    if (cs_n_in)
      so_ff <= 1'b0;
    else if (hold_n_in)
      so_ff <= tx_ff[3'h7 - bitpos_ff];
  end

  assign so_out = so_ff;
  assign so_oe_out = !cs_n_in && hold_n_in && !frame_start_ff && phase_ff == ph_data
    && (op_ff == `OP_ARR_RD || op_ff == `OP_STAT_RD);

  // ==========================================================
  // core side: pin synchronisers
  logic cs_meta_ff, cs_sync_ff, cs_prev_ff;
  logic wp_meta_ff, wp_sync_ff, wp_prev_ff;
  logic id_meta_ff, id_sync_ff, id_seen_ff;
  logic wp_abort_ff;

  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      cs_meta_ff <= 1'b1;
      cs_sync_ff <= 1'b1;
      cs_prev_ff <= 1'b1;
      wp_meta_ff <= 1'b1;
      wp_sync_ff <= 1'b1;
      wp_prev_ff <= 1'b1;
      id_meta_ff <= 1'b0;
      id_sync_ff <= 1'b0;
      link_clr_ff <= 1'b1;
    end
    else
    begin
      cs_meta_ff <= cs_n_in;
      cs_sync_ff <= cs_meta_ff;
      cs_prev_ff <= cs_sync_ff;
      wp_meta_ff <= wp_n_in;
      wp_sync_ff <= wp_meta_ff;
      wp_prev_ff <= wp_sync_ff;
      id_meta_ff <= frame_id_ff;
      id_sync_ff <= id_meta_ff;
      link_clr_ff <= 1'b0;
    end
  end

  // ==========================================================
  // core side: commit on deselect
  logic wel_ff, ppe_ff, busy_ff;
  logic [1:0] bp_ff;
  logic [CYC_W-1:0] busy_cnt_ff;
  logic cs_rise, frame_ok, do_set, do_clr, do_sr_wr, do_arr_wr, busy_end, hw_guard;

  assign cs_rise = cs_sync_ff && !cs_prev_ff;
  assign frame_ok = cs_rise && ready_ff && exact_ff && !busy_ff && (id_sync_ff != id_seen_ff);
  assign hw_guard = ppe_ff && !wp_sync_ff;
  assign do_set = frame_ok && op_ff == `OP_SET_LATCH && bytes_ff == 6'h01;
  assign do_clr = frame_ok && op_ff == `OP_CLR_LATCH && bytes_ff == 6'h01;
  assign do_sr_wr = frame_ok && op_ff == `OP_STAT_WR && bytes_ff == 6'h02 && wel_ff
    && !hw_guard && !(ppe_ff && wp_abort_ff);
  assign do_arr_wr = frame_ok && op_ff == `OP_ARR_WR && bytes_ff >= 6'h04 && wel_ff;
  assign busy_end = busy_ff && busy_cnt_ff == '0;

  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      ready_ff <= 1'b0;
      id_seen_ff <= 1'b0;
      wp_abort_ff <= 1'b0;
    end
    else
    begin
      if (cs_sync_ff)
        ready_ff <= 1'b1;
      if (cs_rise)
        id_seen_ff <= id_sync_ff;
      if (!cs_sync_ff && wp_prev_ff && !wp_sync_ff)
        wp_abort_ff <= 1'b1;
      else if (cs_prev_ff && !cs_sync_ff)
        wp_abort_ff <= 1'b0;
    end
  end

  // self-timed write interval
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      busy_ff <= 1'b0;
      busy_cnt_ff <= '0;
    end
    else if (do_sr_wr || do_arr_wr)
    begin
      busy_ff <= 1'b1;
      busy_cnt_ff <= CYC_W'(WRITE_CYCLES - 1);
    end
    else if (busy_ff)
    begin
      if (busy_end)
        busy_ff <= 1'b0;
      else
        busy_cnt_ff <= busy_cnt_ff - 1'b1;
    end
  end

  // write latch
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
      wel_ff <= 1'b0;
    else if (busy_end)
      wel_ff <= 1'b0;
    else if (do_set)
      wel_ff <= 1'b1;
    else if (do_clr)
      wel_ff <= 1'b0;
  end

  // nonvolatile status bits
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
      {ppe_ff, bp_ff} <= `NV_RESET;
    else if (do_sr_wr)
      {ppe_ff, bp_ff} <= {stat_data_ff[`SR_PPE_BIT], stat_data_ff[`SR_BPH_BIT],
        stat_data_ff[`SR_BPL_BIT]};
  end

  // array programming, protected bytes skipped
  always_ff @(posedge core_clk_in)
  begin
    if (do_arr_wr)
    begin
      for (int i = 0; i < `PAGE_BYTES; i++)
      begin
        if (page_mask_ff[i] && !is_protected(bp_ff, {addr_ff[9:5], i[4:0]}))
          mem_ff[{addr_ff[9:5], i[4:0]}] <= page_buf_ff[i];
      end
    end
  end

  assign sr_value = busy_ff ? `SR_BUSY_VALUE : {ppe_ff, 3'h0, bp_ff, wel_ff, 1'b0};
  assign status_out = sr_value;

  // ==========================================================
  // checks
  logic [CYC_W:0] busy_len_ff;
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in || !busy_ff)
      busy_len_ff <= '0;
    else
      busy_len_ff <= busy_len_ff + 1'b1;
  end

  property p_wel_set;
    @(posedge core_clk_in) disable iff (!rst_n_in)
    do_set |=> wel_ff && sr_value[`SR_LATCH_BIT];
  endproperty
  a_wel_set: assert property (p_wel_set) else $error("latch not set");

  property p_wel_end;
    @(posedge core_clk_in) disable iff (!rst_n_in)
    $fell(busy_ff) |-> !wel_ff && sr_value == {ppe_ff, 3'h0, bp_ff, 2'b00};
  endproperty
  a_wel_end: assert property (p_wel_end) else $error("latch kept after write");

  property p_busy_ones;
    @(posedge core_clk_in) disable iff (!rst_n_in)
    do_sr_wr || do_arr_wr |=> busy_ff && status_out == `SR_BUSY_VALUE;
  endproperty
  a_busy_ones: assert property (p_busy_ones) else $error("status not all ones");

  property p_latch_bit;
    @(posedge core_clk_in) disable iff (!rst_n_in)
    !busy_ff |-> sr_value[`SR_LATCH_BIT] == wel_ff && !sr_value[`SR_WIP_BIT];
  endproperty
  a_latch_bit: assert property (p_latch_bit) else $error("latch bit wrong");

  property p_guard;
    @(posedge core_clk_in) disable iff (!rst_n_in)
    cs_rise && ppe_ff && !wp_sync_ff && op_ff == `OP_STAT_WR
      |=> $stable({ppe_ff, bp_ff}) && !$rose(busy_ff);
  endproperty
  a_guard: assert property (p_guard) else $error("guarded status changed");

  property p_abort;
    @(posedge core_clk_in) disable iff (!rst_n_in)
    cs_rise && ppe_ff && wp_abort_ff && op_ff == `OP_STAT_WR |=> $stable({ppe_ff, bp_ff});
  endproperty
  a_abort: assert property (p_abort) else $error("aborted status write took");

  property p_pin_off;
    @(posedge core_clk_in) disable iff (!rst_n_in)
    frame_ok && op_ff == `OP_STAT_WR && bytes_ff == 6'h02 && wel_ff && !ppe_ff
      |=> busy_ff && ppe_ff == $past(stat_data_ff[7]);
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("status write refused");

  property p_busy_len;
    @(posedge core_clk_in) disable iff (!rst_n_in)
    $fell(busy_ff) |-> $past(busy_len_ff) == (CYC_W + 1)'(WRITE_CYCLES - 1);
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy length wrong");

  property p_exact;
    @(posedge core_clk_in) disable iff (!rst_n_in)
    $rose(busy_ff) |-> $past(exact_ff) && $past(cs_rise) && $past(wel_ff);
  endproperty
  a_exact: assert property (p_exact) else $error("write without whole byte");

  property p_first_bit;
    @(posedge sck_in) disable iff (cs_n_in || link_clr_ff)
    frame_start_ff && hold_n_in |=> bitpos_ff == 3'h1 && shift_ff[0] == $past(si_in);
  endproperty
  a_first_bit: assert property (p_first_bit) else $error("first bit lost");

  property p_hold;
    @(posedge sck_in) disable iff (cs_n_in || link_clr_ff)
    !hold_n_in && !frame_start_ff |=> $stable(bitpos_ff) && $stable(shift_ff);
  endproperty
  a_hold: assert property (p_hold) else $error("sequence moved while paused");

  c_set: cover property (@(posedge core_clk_in) disable iff (!rst_n_in) do_set);
  c_arr: cover property (@(posedge core_clk_in) disable iff (!rst_n_in) do_arr_wr);
  c_sr: cover property (@(posedge core_clk_in) disable iff (!rst_n_in) do_sr_wr);
  c_rd_busy: cover property (@(posedge sck_in) disable iff (cs_n_in)
    link_busy && phase_ff == ph_data && op_ff == `OP_STAT_RD);
endmodule
`default_nettype wire

//--- verif/spi_host_model.sv
// host spi controller model driving the serial eeprom link
`default_nettype none
module spi_host_model (
  input wire logic core_clk_in,
  input wire logic so_in,
  input wire logic so_oe_in,
  output logic sck_out,
  output logic cs_n_out,
  output logic si_out,
  output logic hold_n_out,
  output logic wp_n_out
);
  timeunit 1ns;
  timeprecision 100ps;
  import spi_eeprom_pkg::*;
  // ==========================================
  // idle levels
  initial
  begin
    sck_out = 1'b0;
    cs_n_out = 1'b1;
    si_out = 1'b0;
    hold_n_out = 1'b1;
    wp_n_out = 1'b1;
  end
  // ==========================================
  // framing and bit transfer
  task automatic sel();
    @(negedge core_clk_in);
    cs_n_out = 1'b0;
    #20;
  endtask
  task automatic desel();
    #10;
    @(negedge core_clk_in);
    cs_n_out = 1'b1;
    si_out = ~si_out;
    repeat (5) @(negedge core_clk_in);
  endtask
  task automatic guard(input logic v);
    wp_n_out = v;
  endtask
  // bits top down, sck idles low, so taken at the rising edge
  task automatic bits(input byte_t tx, input int top, input int n, inout byte_t rx);
    for (int i = top; i > top - n; i--)
    begin
      si_out = tx[i];
      #7.5;
      rx[i] = so_in;
      sck_out = 1'b1;
      #7.5;
      sck_out = 1'b0;
    end
  endtask
  // pause with garbage clocks, moved only while sck is low
  task automatic pause(output logic oe_seen);
    hold_n_out = 1'b0;
    repeat (3)
    begin
      #7.5;
      si_out = ~si_out;
      sck_out = 1'b1;
      #7.5;
      sck_out = 1'b0;
    end
    oe_seen = so_oe_in;
    #7.5;
    hold_n_out = 1'b1;
    #7.5;
  endtask
endmodule
`default_nettype wire

//--- verif/testbench.sv
// self-checking bench for the serial eeprom command and protection block
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import spi_eeprom_pkg::*;
  logic core_clk;
  logic rst_n;
  wire logic sck, cs_n, si, hold_n, wp_n, so_line;
  logic so;
  logic so_oe;
  logic oe;
  byte_t status;
  byte_t rx;
  byte_t d [4];
  int n_mismatch;
  int n_checks;
  assign so_line = so_oe ? so : 1'bz;
  // ==========================================
  // instances and clock
  spi_eeprom_command_protect #(.WRITE_CYCLES(20)) i_dut (
    .core_clk_in(core_clk), .rst_n_in(rst_n), .sck_in(sck), .cs_n_in(cs_n),
    .si_in(si), .hold_n_in(hold_n), .wp_n_in(wp_n), .so_out(so),
    .so_oe_out(so_oe), .status_out(status));
  spi_host_model i_host (
    .core_clk_in(core_clk), .so_in(so_line), .so_oe_in(so_oe), .sck_out(sck),
    .cs_n_out(cs_n), .si_out(si), .hold_n_out(hold_n), .wp_n_out(wp_n));
  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // ==========================================
  // shared tasks
  task automatic check(input byte_t seen, input byte_t exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d, mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic tx8(input byte_t b);
    i_host.bits(b, 7, 8, rx);
  endtask
  task automatic cmd(input byte_t op);
    i_host.sel();
    tx8(op);
    i_host.desel();
  endtask
  task automatic addr_phase(input byte_t op, input logic [15:0] a);
    i_host.sel();
    tx8(op);
    tx8(a[15:8]);
    tx8(a[7:0]);
  endtask
  task automatic arr_wr(input logic [15:0] a, input int n, input logic latch);
    if (latch)
      cmd(8'h06);
    addr_phase(8'h02, a);
    for (int i = 0; i < n; i++)
      tx8(d[i]);
    i_host.desel();
  endtask
  task automatic arr_rd(input logic [15:0] a, input int n);
    addr_phase(8'h03, a);
    for (int i = 0; i < n; i++)
    begin
      tx8(8'h00);
      d[i] = rx;
    end
    i_host.desel();
  endtask
  task automatic stat_wr(input byte_t v, input logic drop);
    cmd(8'h06);
    i_host.sel();
    tx8(8'h01);
    if (drop)
      i_host.guard(1'b0);
    tx8(v);
    if (drop)
      i_host.guard(1'b1);
    i_host.desel();
  endtask
  task automatic stat_rd();
    i_host.sel();
    tx8(8'h05);
    tx8(8'h00);
    i_host.desel();
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 100 && status[0] !== 1'b0; i++)
      @(negedge core_clk);
  endtask
  // ==========================================
  // scenarios
  task automatic t_reset();
    check(status, 8'h00);
    check({7'h00, so_oe}, 8'h00);
    stat_rd();
    check(rx, 8'h00);
    $display("reset test done");
  endtask
  task automatic t_latch();
    cmd(8'h06);
    check(status, 8'h02);
    stat_rd();
    check(rx, 8'h02);
    cmd(8'h04);
    check(status, 8'h00);
    $display("latch test done");
  endtask
  task automatic t_array();
    d = '{8'hA5, 8'h00, 8'h00, 8'h00};
    arr_wr(16'h0000, 1, 1'b1);
    check(status, 8'hFF);
    wait_idle();
    check(status, 8'h00);
    d = '{8'h11, 8'h22, 8'h33, 8'h00};
    arr_wr(16'h03FE, 3, 1'b1);
    wait_idle();
    d[0] = 8'h77;
    arr_wr(16'h0300, 1, 1'b1);
    wait_idle();
    arr_rd(16'hFFFE, 3);
    check(d[0], 8'h11);
    check(d[2], 8'hA5);
    arr_rd(16'h03E0, 1);
    check(d[0], 8'h33);
    $display("array test done");
  endtask
  task automatic t_refuse();
    d[0] = 8'h5A;
    arr_wr(16'h0000, 1, 1'b0);
    check(status, 8'h00);
    cmd(8'h06);
    addr_phase(8'h02, 16'h0000);
    i_host.bits(8'h5A, 7, 4, rx);
    i_host.desel();
    check(status, 8'h02);
    cmd(8'h04);
    i_host.sel();
    tx8(8'h06);
    addr_phase(8'h02, 16'h0000);
    tx8(8'h5A);
    i_host.desel();
    check(status, 8'h00);
    i_host.sel();
    tx8(8'hAB);
    tx8(8'h01);
    tx8(8'hFF);
    i_host.desel();
    check(status, 8'h00);
    arr_rd(16'h0000, 1);
    check(d[0], 8'hA5);
    $display("refusal test done");
  endtask
  task automatic t_protect();
    stat_wr(8'h04, 1'b0);
    check(status, 8'hFF);
    stat_rd();
    check(rx, 8'hFF);
    wait_idle();
    check(status, 8'h04);
    d[0] = 8'h5A;
    arr_wr(16'h0300, 1, 1'b1);
    wait_idle();
    arr_rd(16'h0300, 1);
    check(d[0], 8'h77);
    stat_wr(8'hFF, 1'b0);
    wait_idle();
    check(status, 8'h8C);
    $display("protect test done");
  endtask
  task automatic t_guard();
    i_host.guard(1'b0);
    stat_wr(8'h00, 1'b0);
    check(status & 8'hFD, 8'h8C);
    i_host.guard(1'b1);
    stat_wr(8'h00, 1'b1);
    check(status & 8'hFD, 8'h8C);
    stat_wr(8'h00, 1'b0);
    i_host.guard(1'b0);
    check(status, 8'hFF);
    wait_idle();
    check(status, 8'h00);
    i_host.guard(1'b1);
    stat_wr(8'h08, 1'b1);
    check(status, 8'hFF);
    wait_idle();
    check(status, 8'h08);
    i_host.guard(1'b1);
    $display("guard test done");
  endtask
  task automatic t_hold();
    i_host.sel();
    i_host.bits(8'h06, 7, 4, rx);
    #1000;
    i_host.pause(oe);
    i_host.bits(8'h06, 3, 4, rx);
    i_host.desel();
    check(status, 8'h0A);
    i_host.sel();
    tx8(8'h05);
    i_host.bits(8'h00, 7, 3, rx);
    i_host.pause(oe);
    check({7'h00, oe}, 8'h00);
    i_host.bits(8'h00, 4, 5, rx);
    i_host.desel();
    check(rx, 8'h0A);
    $display("pause test done");
  endtask
  task automatic t_rereset();
    cmd(8'h06);
    check(status, 8'h0A);
    @(negedge core_clk);
    rst_n = 1'b0;
    repeat (2) @(negedge core_clk);
    check(status, 8'h00);
    rst_n = 1'b1;
    repeat (5) @(negedge core_clk);
    check({7'h00, so_oe}, 8'h00);
    stat_rd();
    check(rx, 8'h00);
    cmd(8'h06);
    check(status, 8'h02);
    $display("second reset test done");
  endtask
  // ==========================================
  // sequence and watchdog
  initial
  begin
    n_mismatch = 0;
    n_checks = 0;
    rst_n = 1'b0;
    repeat (2) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (5) @(negedge core_clk);
    t_reset();
    t_latch();
    t_array();
    t_refuse();
    t_protect();
    t_guard();
    t_hold();
    t_rereset();
    results();
  end
  initial
  begin
    #200000;
    n_mismatch++;
    results();
  end
endmodule
`default_nettype wire
